// ---- verilog/gxrc_top.sv ----
// Clock, reset and status controller of a four-channel gigabit Ethernet
// transceiver block, with its AXI4-Lite register slave.
// Assumes one 100 MHz clock; PLL and FIFO clocks are routed as signals.
//
// What this block does
// - Transmit FIFO clock input writes transmit FIFO.
// - Absent FIFO clock input falls back to core clock.
// - Receive FIFO clock input reads receive FIFO.
// - Core clock output copies PLL clock when used.
// - Reference pin drives fixed shared line per block.
// - Shared line 2 feeds only receiver PLLs.
// - Unused channels of the block become unavailable.
// - Per-channel receive digital reset.
// - Per-channel transmit digital reset.
// - Per-channel receive analog and PLL reset.
// - Block reset clears every channel and PLL.
// - Duplex, receive-only and transmit-only modes.
// - Transmit parallel data is one 8-bit word; receive data is one 10-bit word.
// - Aligner seeks both comma disparities.
// - Default line rate is 1250 Mbps.
// - Multiplier accepts only 2,4,5,8,10,16,20.
// - Signal present is always asserted.
// - Receiver lock output is active low.
// - Alignment pulse lasts exactly one clock.
// - Transmit FIFO has no frequency error flag.
`timescale 1ns/1ps
`include "gxrc_map.svh"
module gxrc_top
  import gxrc_pkg::*;
#(
  parameter int NCH         = 4,
  parameter int LOCK_CYCLES = `GXRC_LOCK_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              tx_pll_clk,
  input  wire logic              tx_coreclk,
  input  wire logic              rx_coreclk,
  output logic                   coreclk_out,
  output logic                   tx_fifo_wr_clk,
  output logic                   rx_fifo_rd_clk,
  output logic [2:0]             shared_ref_line_drive,
  input  wire logic [NCH*10-1:0] rx_symbol,
  input  wire logic [NCH*8-1:0]  tx_byte_in,
  output logic [NCH*10-1:0]      rx_aligned,
  output logic [NCH*8-1:0]       tx_byte_out,
  output logic [NCH-1:0]         rx_sync,
  output logic [NCH-1:0]         rx_locked_n,
  output logic [NCH-1:0]         rx_signal_present
);
  //////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0]     ctrl_reg, ctrl_next;       // Clock options, block reset, mode.
  logic [15:0]    chrst_reg, chrst_next;     // Channel resets and active mask.
  logic [4:0]     mult_reg, mult_next;       // Reference clock multiplier.
  logic [3:0]     refsel_reg, refsel_next;   // Block number and density.
  logic           rej_reg, rej_next;         // Last multiplier write was refused.
  logic [NCH-1:0] sig_reg, sig_next;         // Signal present indication.
  gxrc_wr_state_t wst_reg, wst_next;         // Write channel state.
  gxrc_rd_state_t rst_reg, rst_next;         // Read channel state.
  logic           awh_reg, awh_next;         // Write address held.
  logic           wh_reg, wh_next;           // Write data held.
  logic [7:0]     awa_reg, awa_next;         // Held write address.
  logic [31:0]    wd_reg, wd_next;           // Held write data.
  logic [3:0]     ws_reg, ws_next;           // Held write strobes.
  logic [1:0]     bresp_reg, bresp_next;
  logic [31:0]    rdata_reg, rdata_next;
  logic [1:0]     rresp_reg, rresp_next;
  logic [31:0]    status;
  logic           ref_warn, line_tx_ok;
  gxrc_mode_t     mode;
  gxrc_chan_rst_t crst [NCH];

  assign mode = gxrc_mode_t'(ctrl_reg[`GXRC_CTRL_MODE_LO +: 2]);

  // Merge a write under its byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Factors the multiplier can really produce.
  function automatic logic legal_mult(input logic [4:0] f);
    return f == 5'h02 || f == 5'h04 || f == 5'h05 || f == 5'h08 ||
           f == 5'h0A || f == 5'h10 || f == 5'h14;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Clock routing. These are clock nets, not data, so they stay combinational.
  always_comb begin
    coreclk_out    = ctrl_reg[`GXRC_CTRL_PLL_USED] & tx_pll_clk;
    // Writer-side clock; frequency lock is the host's duty and nothing here
    // can flag a mismatch, the FIFO only absorbs phase.
    tx_fifo_wr_clk = ctrl_reg[`GXRC_CTRL_TXCK_EN] ? tx_coreclk : coreclk_out;
    rx_fifo_rd_clk = ctrl_reg[`GXRC_CTRL_RXCK_EN] ? rx_coreclk : coreclk_out;
  end

  // Shared reference line driven by this block's dedicated reference pin.
  always_comb begin
    shared_ref_line_drive = 3'b000;
    if (!refsel_reg[3]) begin
      if (refsel_reg[2:0] == 3'h0) begin
        shared_ref_line_drive = 3'b100;
      end else if (refsel_reg[2:0] == 3'h1) begin
        shared_ref_line_drive = 3'b001;
      end
    end else if (refsel_reg[2:0] == 3'h1) begin
      shared_ref_line_drive = 3'b100;
    end else if (refsel_reg[2:0] == 3'h2) begin
      shared_ref_line_drive = 3'b001;
    end else if (refsel_reg[2:0] == 3'h3) begin
      shared_ref_line_drive = 3'b010;
    end
    // Line 2 stops at receiver PLLs, so it can never feed another transmit PLL.
    line_tx_ok = |shared_ref_line_drive[1:0];
    // Low factors without a dedicated pin, or factor 2 untrained, are flagged.
    ref_warn = (mult_reg <= 5'h05 && !ctrl_reg[`GXRC_CTRL_REF_DED]) ||
               (mult_reg == 5'h02 && !ctrl_reg[`GXRC_CTRL_TRAINED]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Effective channel resets: bus reset, block reset, channel bits, unused
  // channels and the halves switched off by the direction mode.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      logic off;
      logic blk;
      off = ~chrst_reg[`GXRC_CHRST_ACT_LO + i];
      blk = ~aresetn | ctrl_reg[`GXRC_CTRL_BLK_RST];
      crst[i].rx_dig = blk | off | chrst_reg[`GXRC_CHRST_RXD_LO + i] | (mode == GXRC_TX_ONLY);
      crst[i].tx_dig = blk | off | chrst_reg[`GXRC_CHRST_TXD_LO + i] | (mode == GXRC_RX_ONLY);
      crst[i].rx_ana = blk | off | chrst_reg[`GXRC_CHRST_RXA_LO + i] | (mode == GXRC_TX_ONLY);
    end
  end

  // One instance per channel.
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    gxrc_chan #(.LOCK_CYCLES(LOCK_CYCLES)) u_chan (
      .aclk        (aclk),
      .rst         (crst[g]),
      .rx_symbol   (rx_symbol[g*10 +: 10]),
      .tx_byte_in  (tx_byte_in[g*8 +: 8]),
      .rx_aligned  (rx_aligned[g*10 +: 10]),
      .rx_sync     (rx_sync[g]),
      .rx_locked_n (rx_locked_n[g]),
      .tx_byte_out (tx_byte_out[g*8 +: 8])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word seen by software.
  always_comb begin
    status        = 32'h00000000;
    status[3:0]   = rx_locked_n;
    status[7:4]   = rx_signal_present;
    status[8]     = rej_reg;
    status[9]     = ref_warn;
    status[12:10] = shared_ref_line_drive;
    status[13]    = line_tx_ok;
    status[17:14] = ~chrst_reg[`GXRC_CHRST_ACT_LO +: 4];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave and register next values. Address and data may arrive in
  // either order; the response is raised once both are held.
  always_comb begin
    logic        do_wr;
    logic [31:0] m;
    ctrl_next   = ctrl_reg;
    chrst_next  = chrst_reg;
    mult_next   = mult_reg;
    refsel_next = refsel_reg;
    rej_next    = rej_reg;
    sig_next    = '1;
    wst_next    = wst_reg;
    rst_next    = rst_reg;
    awh_next    = awh_reg;
    wh_next     = wh_reg;
    awa_next    = awa_reg;
    wd_next     = wd_reg;
    ws_next     = ws_reg;
    bresp_next  = bresp_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    do_wr       = 1'b0;
    m           = 32'h00000000;
    case (wst_reg)
      GXRC_WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          awh_next = 1'b1;
          awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wh_next = 1'b1;
          wd_next = s_axi_wdata;
          ws_next = s_axi_wstrb;
        end
        do_wr = awh_next && wh_next;
      end
      GXRC_WR_RESP: begin
        if (s_axi_bready) begin
          wst_next = GXRC_WR_IDLE;
        end
      end
      default: wst_next = GXRC_WR_IDLE;
    endcase
    if (do_wr) begin
      awh_next   = 1'b0;
      wh_next    = 1'b0;
      wst_next   = GXRC_WR_RESP;
      bresp_next = `GXRC_RESP_OKAY;
      if (awa_next[7:2] == `GXRC_OFF_CTRL >> 2) begin
        m = merge({24'h000000, ctrl_reg}, wd_next, ws_next);
        ctrl_next = m[7:0];
        // The unused mode code leaves the mode as it was.
        if (m[`GXRC_CTRL_MODE_LO +: 2] == 2'h3) begin
          ctrl_next[`GXRC_CTRL_MODE_LO +: 2] = ctrl_reg[`GXRC_CTRL_MODE_LO +: 2];
        end
      end else if (awa_next[7:2] == `GXRC_OFF_CHRST >> 2) begin
        m = merge({16'h0000, chrst_reg}, wd_next, ws_next);
        chrst_next = m[15:0];
      end else if (awa_next[7:2] == `GXRC_OFF_MULT >> 2) begin
        m = merge({27'h0000000, mult_reg}, wd_next, ws_next);
        rej_next = ~legal_mult(m[4:0]);
        if (legal_mult(m[4:0])) begin
          mult_next = m[4:0];
        end
      end else if (awa_next[7:2] == `GXRC_OFF_REFSEL >> 2) begin
        m = merge({28'h0000000, refsel_reg}, wd_next, ws_next);
        refsel_next = m[3:0];
      end else if (awa_next[7:2] == `GXRC_OFF_STATUS >> 2 || awa_next[7:2] == `GXRC_OFF_RATE >> 2) begin
        bresp_next = `GXRC_RESP_OKAY;
      end else begin
        bresp_next = `GXRC_RESP_SLVERR;
      end
    end
    case (rst_reg)
      GXRC_RD_IDLE: begin
        if (s_axi_arvalid) begin
          rst_next   = GXRC_RD_RESP;
          rresp_next = `GXRC_RESP_OKAY;
          rdata_next = 32'h00000000;
          if (s_axi_araddr[7:2] == `GXRC_OFF_CTRL >> 2) begin
            rdata_next[7:0] = ctrl_reg;
          end else if (s_axi_araddr[7:2] == `GXRC_OFF_CHRST >> 2) begin
            rdata_next[15:0] = chrst_reg;
          end else if (s_axi_araddr[7:2] == `GXRC_OFF_MULT >> 2) begin
            rdata_next[4:0] = mult_reg;
          end else if (s_axi_araddr[7:2] == `GXRC_OFF_REFSEL >> 2) begin
            rdata_next[3:0] = refsel_reg;
          end else if (s_axi_araddr[7:2] == `GXRC_OFF_STATUS >> 2) begin
            rdata_next = status;
          end else if (s_axi_araddr[7:2] == `GXRC_OFF_RATE >> 2) begin
            rdata_next = `GXRC_LINE_RATE_MBPS;
          end else begin
            rresp_next = `GXRC_RESP_SLVERR;
          end
        end
      end
      GXRC_RD_RESP: begin
        if (s_axi_rready) begin
          rst_next = GXRC_RD_IDLE;
        end
      end
      default: rst_next = GXRC_RD_IDLE;
    endcase
  end

  // Registers only; the bus reset returns every field to its initial value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= `GXRC_CTRL_RESET;
      chrst_reg  <= `GXRC_CHRST_RESET;
      mult_reg   <= `GXRC_MULT_RESET;
      refsel_reg <= `GXRC_REFSEL_RESET;
      rej_reg    <= 1'b0;
      sig_reg    <= '1;
      wst_reg    <= GXRC_WR_IDLE;
      rst_reg    <= GXRC_RD_IDLE;
      awh_reg    <= 1'b0;
      wh_reg     <= 1'b0;
      awa_reg    <= 8'h00;
      wd_reg     <= 32'h00000000;
      ws_reg     <= 4'h0;
      bresp_reg  <= 2'h0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= 2'h0;
    end else begin
      ctrl_reg   <= ctrl_next;
      chrst_reg  <= chrst_next;
      mult_reg   <= mult_next;
      refsel_reg <= refsel_next;
      rej_reg    <= rej_next;
      sig_reg    <= sig_next;
      wst_reg    <= wst_next;
      rst_reg    <= rst_next;
      awh_reg    <= awh_next;
      wh_reg     <= wh_next;
      awa_reg    <= awa_next;
      wd_reg     <= wd_next;
      ws_reg     <= ws_next;
      bresp_reg  <= bresp_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_awready     = (wst_reg == GXRC_WR_IDLE) && !awh_reg;
  assign s_axi_wready      = (wst_reg == GXRC_WR_IDLE) && !wh_reg;
  assign s_axi_bvalid      = (wst_reg == GXRC_WR_RESP);
  assign s_axi_bresp       = bresp_reg;
  assign s_axi_arready     = (rst_reg == GXRC_RD_IDLE);
  assign s_axi_rvalid      = (rst_reg == GXRC_RD_RESP);
  assign s_axi_rdata       = rdata_reg;
  assign s_axi_rresp       = rresp_reg;
  assign rx_signal_present = sig_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_both_held;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_seen;
    s_axi_bvalid && s_axi_bresp != 2'h1;
  endsequence

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_both_held |=> s_resp_seen) else $error("write response missing");
  a_sig_present: assert property (@(posedge aclk) disable iff (!aresetn)
    &rx_signal_present) else $error("signal present dropped");
  a_sync_width: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_sync[0] |=> !rx_sync[0]) else $error("alignment pulse too long");
  a_rx_rst_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    crst[0].rx_dig [*2] |-> !rx_sync[0] && rx_aligned[9:0] == 10'h000)
    else $error("receive logic active under reset");
  a_tx_rst_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    crst[1].tx_dig |=> tx_byte_out[15:8] == 8'h00) else $error("transmit byte under reset");
  a_lock_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    crst[0].rx_ana |=> rx_locked_n[0] [*2]) else $error("lock seen during analog reset");
  a_blk_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[`GXRC_CTRL_BLK_RST] |=> &rx_locked_n && tx_byte_out == '0)
    else $error("block reset left a channel running");
  a_mult_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    legal_mult(mult_reg)) else $error("illegal multiplier stored");
  a_ref_line: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(shared_ref_line_drive) &&
    (refsel_reg != 4'h8 || shared_ref_line_drive == 3'b000))
    else $error("reference line mapping wrong");
  a_coreclk_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[`GXRC_CTRL_PLL_USED] |-> coreclk_out == tx_pll_clk)
    else $error("core clock not a copy of the PLL clock");
endmodule // gxrc_top

// ---- verilog/gxrc_map.svh ----
// Register offsets, field positions, reset values and timing counts of the
// transceiver clock and reset controller; included by the package users.
`ifndef GXRC_MAP_SVH
`define GXRC_MAP_SVH

// Register byte offsets on the AXI4-Lite bus.
`define GXRC_OFF_CTRL      8'h00
`define GXRC_OFF_CHRST     8'h04
`define GXRC_OFF_MULT      8'h08
`define GXRC_OFF_REFSEL    8'h0C
`define GXRC_OFF_STATUS    8'h10
`define GXRC_OFF_RATE      8'h14

// Control register fields.
`define GXRC_CTRL_TXCK_EN  0
`define GXRC_CTRL_RXCK_EN  1
`define GXRC_CTRL_PLL_USED 2
`define GXRC_CTRL_BLK_RST  3
`define GXRC_CTRL_MODE_LO  4
`define GXRC_CTRL_TRAINED  6
`define GXRC_CTRL_REF_DED  7
`define GXRC_CTRL_RESET    8'h84

// Channel reset register: fields are four bits wide, one bit per channel.
`define GXRC_CHRST_RXD_LO  0
`define GXRC_CHRST_TXD_LO  4
`define GXRC_CHRST_RXA_LO  8
`define GXRC_CHRST_ACT_LO  12
`define GXRC_CHRST_RESET   16'hF000

// Multiplier and reference selection.
`define GXRC_MULT_RESET    5'h0A
`define GXRC_REFSEL_RESET  4'h0

// Fixed line rate in megabits per second.
`define GXRC_LINE_RATE_MBPS 32'h000004E2

// AXI responses.
`define GXRC_RESP_OKAY     2'h0
`define GXRC_RESP_SLVERR   2'h2

// Comma forms of the 10-bit alignment symbol, both disparities.
`define GXRC_COMMA_NEG     10'h0FA
`define GXRC_COMMA_POS     10'h305

// Receiver PLL lock time and the clock period it is counted in.
`define GXRC_LOCK_TIME_NS  10000
`define GXRC_CLK_PERIOD_NS 10
`define GXRC_LOCK_CYCLES   (`GXRC_LOCK_TIME_NS / `GXRC_CLK_PERIOD_NS)

`endif

// ---- verilog/gxrc_pkg.sv ----
// Types shared by the transceiver clock and reset controller files.
// Assumes the map header is included wherever offsets are needed.
package gxrc_pkg;
  // Channel operating direction.
  typedef enum logic [1:0] {GXRC_DUPLEX, GXRC_RX_ONLY, GXRC_TX_ONLY} gxrc_mode_t;
  // Effective per-channel resets, active high.
  typedef struct packed {
    logic rx_dig;
    logic tx_dig;
    logic rx_ana;
  } gxrc_chan_rst_t;
  // Bus slave states.
  typedef enum {GXRC_WR_IDLE, GXRC_WR_RESP} gxrc_wr_state_t;
  typedef enum {GXRC_RD_IDLE, GXRC_RD_RESP} gxrc_rd_state_t;
endpackage

// ---- verilog/gxrc_chan.sv ----
// One transceiver channel: comma aligner, receiver PLL lock timer and the
// 8-bit transmit data register, each held by its own channel reset.
// Assumes resets arrive synchronous to aclk and already merged.
`timescale 1ns/1ps
`include "gxrc_map.svh"
module gxrc_chan
  import gxrc_pkg::*;
#(
  parameter int LOCK_CYCLES = `GXRC_LOCK_CYCLES
) (
  input  wire logic           aclk,
  input  wire gxrc_chan_rst_t rst,
  input  wire logic [9:0]     rx_symbol,
  input  wire logic [7:0]     tx_byte_in,
  output logic      [9:0]     rx_aligned,
  output logic                rx_sync,
  output logic                rx_locked_n,
  output logic      [7:0]     tx_byte_out
);
  logic [9:0]  prev_reg, prev_next;         // Previous raw symbol.
  logic [3:0]  align_reg, align_next;       // Current boundary offset.
  logic        valid_reg, valid_next;       // A boundary has been found.
  logic        sync_reg, sync_next;         // One-cycle alignment pulse.
  logic [9:0]  word_reg, word_next;         // Aligned receive word.
  logic [15:0] lock_reg, lock_next;         // Lock timer.
  logic [7:0]  txb_reg, txb_next;           // Transmit parallel byte.
  logic [19:0] window;
  logic        hit;
  logic [3:0]  hit_off;

  assign window = {prev_reg, rx_symbol};

  // Search every bit offset for either comma form; the lowest offset wins.
  always_comb begin
    hit     = 1'b0;
    hit_off = 4'h0;
    for (int k = 9; k >= 0; k--) begin
      if (window[19-k -: 10] == `GXRC_COMMA_NEG || window[19-k -: 10] == `GXRC_COMMA_POS) begin
        hit     = 1'b1;
        hit_off = 4'(k);
      end
    end
  end

  // Next-state of the aligner, lock timer and transmit byte.
  always_comb begin
    prev_next  = rx_symbol;
    align_next = align_reg;
    valid_next = valid_reg;
    sync_next  = 1'b0;
    word_next  = 10'h000;
    lock_next  = lock_reg;
    txb_next   = tx_byte_in;
    for (int k = 0; k < 10; k++) begin
      if (align_reg == 4'(k)) begin
        word_next = window[19-k -: 10];
      end
    end
    if (hit && (!valid_reg || hit_off != align_reg)) begin
      align_next = hit_off;
      valid_next = 1'b1;
      // Suppressing a back-to-back pulse keeps it one clock wide.
      sync_next  = ~sync_reg;
    end
    if (rst.rx_dig) begin
      prev_next  = 10'h000;
      align_next = 4'h0;
      valid_next = 1'b0;
      sync_next  = 1'b0;
      word_next  = 10'h000;
    end
    if (lock_reg != 16'(LOCK_CYCLES)) begin
      lock_next = lock_reg + 16'h0001;
    end
    if (rst.rx_ana) begin
      lock_next = 16'h0000;
    end
    if (rst.tx_dig) begin
      txb_next = 8'h00;
    end
  end

  // Registers only; every reset path is folded into the next values.
  always_ff @(posedge aclk) begin
    prev_reg  <= prev_next;
    align_reg <= align_next;
    valid_reg <= valid_next;
    sync_reg  <= sync_next;
    word_reg  <= word_next;
    lock_reg  <= lock_next;
    txb_reg   <= txb_next;
  end

  assign rx_aligned  = word_reg;
  assign rx_sync     = sync_reg;
  assign rx_locked_n = (lock_reg != 16'(LOCK_CYCLES));
  assign tx_byte_out = txb_reg;
endmodule // gxrc_chan

// ---- verif/gxrc_fabric_model.sv ----
// Fabric clock source: transmit PLL clock and both FIFO clocks.
// Assumes the bench routes them to the controller as plain signals.
`timescale 1ns/1ps
module gxrc_fabric_model (
  output logic pll_clk,
  output logic tx_ck,
  output logic rx_ck
);
  // The FIFO write clock shares the PLL rate; only its phase is offset.
  initial pll_clk = 1'b0;
  always #4 pll_clk = ~pll_clk;
  assign #3 tx_ck = pll_clk;
  // The read clock is free and unrelated, so a wrong mux choice shows.
  initial rx_ck = 1'b0;
  always #7 rx_ck = ~rx_ck;
endmodule // gxrc_fabric_model

// ---- verif/gxrc_top_bench.sv ----
// Bench of the clock and reset controller, with a register mirror.
// Assumes the fabric model supplies the PLL and FIFO clocks.
`timescale 1ns/1ps
module gxrc_top_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_pll_clk, tx_coreclk, rx_coreclk;
  logic coreclk_out, tx_fifo_wr_clk, rx_fifo_rd_clk;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, tx_byte_in, tx_byte_out, d;
  logic [3:0]  s_axi_wstrb, rx_sync, rx_locked_n, rx_signal_present;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  shared_ref_line_drive, e;
  logic [39:0] rx_symbol, rx_aligned;
  int          failures, checks, n, m[int];
  gxrc_top #(.NCH(4), .LOCK_CYCLES(8)) gxrc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_pll_clk, .tx_coreclk, .rx_coreclk, .coreclk_out, .tx_fifo_wr_clk, .rx_fifo_rd_clk,
    .shared_ref_line_drive, .rx_symbol, .tx_byte_in, .rx_aligned, .tx_byte_out, .rx_sync, .rx_locked_n,
    .rx_signal_present);
  gxrc_fabric_model gxrc_fabric_model_inst (.pll_clk(tx_pll_clk), .tx_ck(tx_coreclk), .rx_ck(rx_coreclk));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [63:0] v, logic [63:0] x);
    checks++;
    if (v !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, x, v);
    end
  endtask
  // Each item is held until the rising edge at which its ready is seen high.
  task automatic wr(int a, int v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {8'(a), 32'(v), 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(int a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {8'(a), 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // Mirror write: an illegal factor and mode code three leave old values.
  task automatic mw(int a, int v);
    wr(a, v);
    chk("bresp", r, (m.exists(a) || a == 16) ? 0 : 2);
    if (a == 0) m[0] = ((v & 'h30) == 'h30) ? (v & 'hCF) | (m[0] & 'h30) : v & 'hFF;
    if (a == 4) m[4] = v & 'hFFFF;
    if (a == 8 && (v inside {2, 4, 5, 8, 10, 16, 20})) m[8] = v;
    if (a == 12) m[12] = v & 15;
    rd(a);
    chk("rdata", d, m.exists(a) ? m[a] : 0);
    chk("rresp", r, (m.exists(a) || a == 16) ? 0 : 2);
    @(negedge aclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #300us;
    failures++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(23));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_byte_in, rx_symbol} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hF;
    m[0] = 'h84;
    m[4] = 'hF000;
    m[8] = 'h0A;
    m[12] = 0;
    m[20] = 1250;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (m[a]) mw(a, 'h33);
    mw(8'h18 + 4 * ($urandom % 58), $urandom);
    mw(0, 'h84);
    // Reactivate every channel and give the lock timer time to run out.
    mw(4, 'hF000);
    repeat (10) @(negedge aclk);
    chk("sigdet", rx_signal_present, 4'hF);
    chk("locked", rx_locked_n, 4'h0);
    for (int f = 0; f < 32; f++) begin
      mw(8, f);
      rd(16);
      chk("reject", d[9:8], {m[8] == 2, m[8] != f});
    end
    for (int v = 0; v < 16; v++) begin
      mw(12, v);
      e = v[3] ? (v[2:0] == 1 ? 4 : v[2:0] == 2 ? 1 : v[2:0] == 3 ? 2 : 0) : (v[2:0] == 0 ? 4 : v[2:0] == 1);
      rd(16);
      chk("line", {shared_ref_line_drive, d[13:10]}, {e, |e[1:0], e});
    end
    repeat (8) begin
      mw(0, $urandom & 'hF7);
      repeat (5) begin
        #3.1;
        chk("core", coreclk_out, tx_pll_clk & m[0][2]);
        chk("txfifo", tx_fifo_wr_clk, m[0][0] ? tx_coreclk : coreclk_out);
        chk("rxfifo", rx_fifo_rd_clk, m[0][1] ? rx_coreclk : coreclk_out);
      end
    end
    mw(0, 'h84);
    @(posedge aclk) tx_byte_in <= $urandom;
    rx_symbol <= {20'h0, 10'h305, 10'h0FA};
    @(posedge aclk) rx_symbol <= '0;
    n = 0;
    repeat (6) @(negedge aclk) n += rx_sync[0] + 16 * rx_sync[1];
    chk("sync", n, 17);
    chk("txbyte", tx_byte_out, tx_byte_in);
    // Alternating bits hold no comma, so every channel keeps offset zero.
    @(posedge aclk) rx_symbol <= {4{10'h155}};
    repeat (3) @(negedge aclk);
    chk("aligned", rx_aligned, {4{10'h155}});
    mw(0, 'hA4);
    chk("txonly", {tx_byte_out, rx_locked_n}, {tx_byte_in, 4'hF});
    mw(0, 'h84);
    mw(4, 'hF0F0);
    chk("txrst", {tx_byte_out, rx_locked_n}, 36'h0);
    mw(4, 'hFF00);
    chk("rxana", rx_locked_n, 4'hF);
    mw(0, 'h8C);
    chk("blkrst", {tx_byte_out, rx_locked_n}, 36'hF);
    mw(0, 'h94);
    chk("rxonly", tx_byte_out, 0);
    // A second bus reset in mid-run must restore the channel reset word.
    @(posedge aclk) aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4);
    chk("rstval", d, 'hF000);
    end_of_test;
  end
endmodule // gxrc_top_bench
